//--- src/dpsc_defs.vh
`ifndef DPSC_DEFS_VH
`define DPSC_DEFS_VH

// -----------------------------------------------------------------------------
// Widths
// -----------------------------------------------------------------------------
`define DPSC_AW 19
`define DPSC_DW 18
`define DPSC_LANE_W 9
`define DPSC_FLAG_AW 3

// -----------------------------------------------------------------------------
// Command codes
// -----------------------------------------------------------------------------
`define DPSC_CMD_RD 2'h0
`define DPSC_CMD_WR 2'h1
`define DPSC_CMD_SEM_RD 2'h2
`define DPSC_CMD_SEM_WR 2'h3

// -----------------------------------------------------------------------------
// Timing: phase length in clk_sys cycles at 10 MHz
// -----------------------------------------------------------------------------
`define DPSC_CLK_NS 100
`define DPSC_PHASE_NS 100
`define DPSC_PHASE_CYC ((`DPSC_PHASE_NS + `DPSC_CLK_NS - 1) / `DPSC_CLK_NS)
`define DPSC_TAP_CLK_MHZ 10
`define DPSC_SYS_CLK_MHZ 10
`define DPSC_TCK_DIV (`DPSC_SYS_CLK_MHZ / `DPSC_TAP_CLK_MHZ)

`endif

//--- src/dpsc_sync2.v
`timescale 1ns/1ps

// -----------------------------------------------------------------------------
// Two-flop synchroniser, vector wide
// -----------------------------------------------------------------------------
module dpsc_sync2 #(
    parameter W = 1
) (
    clk_sys,
    rst,
    din,
    dout
);
    input wire clk_sys;
    input wire rst;
    input wire [W-1:0] din;
    output reg [W-1:0] dout;

    reg [W-1:0] meta_q;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

//--- src/dpsc_port_host.v
`timescale 1ns/1ps
// Behaviour
// - Avoid test-port activity while sleep is asserted; recommendation only. Test clock held low in sleep; tap_rst_n still follows tap_rst_req.
// - Flag read: chip deselected, flag select low, R/W high, OE low.
// - Flag write on R/W rising edge, stores data bit 0.
// - Test clock never exceeds 10 MHz.

`include "dpsc_defs.vh"

module dpsc_port_host (
    input wire clk_sys,
    input wire rst,
    input wire req_valid,
    input wire [1:0] req_cmd,
    input wire [`DPSC_AW-1:0] req_addr,
    input wire [`DPSC_DW-1:0] req_wdata,
    input wire [1:0] req_lane_n,
    output reg req_ready,
    output reg rsp_valid,
    output reg [`DPSC_DW-1:0] rsp_rdata,
    input wire tok_req,
    input wire [`DPSC_FLAG_AW-1:0] tok_flag,
    output reg tok_done,
    output reg tok_granted,
    input wire sleep_req,
    input wire master_req,
    input wire tap_rst_req,
    output reg chip_enable_active_low,
    output reg chip_enable_active_high,
    output reg rw_n,
    output reg oe_n,
    output reg flag_access_select,
    output reg upper_lane_select,
    output reg lower_lane_select,
    output reg sleep_input,
    output reg [`DPSC_AW-1:0] word_address,
    output reg [`DPSC_DW-1:0] data_lines_o,
    output reg data_lines_oe,
    input wire [`DPSC_DW-1:0] data_lines_i,
    output reg master_select,
    input wire busy_n_i,
    output reg busy_n_o,
    output reg busy_n_oe,
    input wire int_n_i,
    output reg busy_seen_n,
    output reg int_seen_n,
    output reg tap_clk,
    output reg tap_rst_n
);

    // -------------------------------------------------------------------------
    // States
    // -------------------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_ACT = 3'h2;
    localparam ST_DONE = 3'h3;
    localparam ST_RECOV = 3'h4;

    localparam [7:0] PHASE = `DPSC_PHASE_CYC;

    // -------------------------------------------------------------------------
    // Pin input synchronisers
    // -------------------------------------------------------------------------
    wire [`DPSC_DW-1:0] data_s;
    wire [1:0] stat_s;

    dpsc_sync2 #(.W(`DPSC_DW)) u_sync_data (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(data_lines_i),
        .dout(data_s)
    );

    dpsc_sync2 #(.W(2)) u_sync_stat (
        .clk_sys(clk_sys),
        .rst(rst),
        .din({busy_n_i, int_n_i}),
        .dout(stat_s)
    );

    function is_flag_cmd;
        input [1:0] c;
        begin
            is_flag_cmd = (c == `DPSC_CMD_SEM_RD) || (c == `DPSC_CMD_SEM_WR);
        end
    endfunction

    function is_write_cmd;
        input [1:0] c;
        begin
            is_write_cmd = (c == `DPSC_CMD_WR) || (c == `DPSC_CMD_SEM_WR);
        end
    endfunction

    // -------------------------------------------------------------------------
    // Access sequencer
    // -------------------------------------------------------------------------
    reg [2:0] state_q;
    reg [7:0] cnt_q;
    reg [1:0] cmd_q;
    reg tok_busy_q;
    reg [`DPSC_FLAG_AW-1:0] tok_flag_q;

    wire phase_end = (cnt_q == 8'h00);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            cmd_q <= 2'h0;
            tok_busy_q <= 1'b0;
            tok_flag_q <= 3'h0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 18'h00000;
            tok_done <= 1'b0;
            tok_granted <= 1'b0;
            chip_enable_active_low <= 1'b1;
            chip_enable_active_high <= 1'b0;
            rw_n <= 1'b1;
            oe_n <= 1'b1;
            flag_access_select <= 1'b1;
            upper_lane_select <= 1'b1;
            lower_lane_select <= 1'b1;
            word_address <= 19'h00000;
            data_lines_o <= 18'h00000;
            data_lines_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            tok_done <= 1'b0;
            req_ready <= 1'b0;
            if (!phase_end) begin
                cnt_q <= cnt_q - 8'h01;
            end
            case (state_q)
            ST_IDLE: begin
                // No access while asleep or about to sleep
                if (sleep_input || sleep_req) begin
                    req_ready <= 1'b0;
                end else if (tok_req && !tok_busy_q) begin
                    // Token step one: write zero to flag
                    tok_busy_q <= 1'b1;
                    tok_flag_q <= tok_flag;
                    cmd_q <= `DPSC_CMD_SEM_WR;
                    word_address <= {16'h0000, tok_flag};
                    data_lines_o <= 18'h00000;
                    upper_lane_select <= 1'b0;
                    lower_lane_select <= 1'b0;
                    cnt_q <= PHASE;
                    state_q <= ST_SETUP;
                end else if (tok_busy_q) begin
                    // Token step two: read it back
                    cmd_q <= `DPSC_CMD_SEM_RD;
                    word_address <= {16'h0000, tok_flag_q};
                    upper_lane_select <= 1'b0;
                    lower_lane_select <= 1'b0;
                    cnt_q <= PHASE;
                    state_q <= ST_SETUP;
                end else if (req_valid) begin
                    cmd_q <= req_cmd;
                    word_address <= req_addr;
                    data_lines_o <= req_wdata;
                    upper_lane_select <= req_lane_n[1];
                    lower_lane_select <= req_lane_n[0];
                    req_ready <= 1'b1;
                    cnt_q <= PHASE;
                    state_q <= ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (is_flag_cmd(cmd_q)) begin
                    // Chip stays deselected for flag access
                    chip_enable_active_low <= 1'b1;
                    chip_enable_active_high <= 1'b0;
                    flag_access_select <= 1'b0;
                end else begin
                    chip_enable_active_low <= 1'b0;
                    chip_enable_active_high <= 1'b1;
                    flag_access_select <= 1'b1;
                end
                if (is_write_cmd(cmd_q)) begin
                    rw_n <= 1'b0;
                    data_lines_oe <= 1'b1;
                    if (cmd_q == `DPSC_CMD_SEM_WR) begin
                        lower_lane_select <= 1'b0;
                    end
                end else begin
                    rw_n <= 1'b1;
                    oe_n <= 1'b0;
                    data_lines_oe <= 1'b0;
                end
                if (phase_end) begin
                    cnt_q <= PHASE;
                    state_q <= ST_ACT;
                end
            end
            ST_ACT: begin
                if (phase_end) begin
                    // Rising R/W with data still held stores the flag
                    rw_n <= 1'b1;
                    oe_n <= 1'b1;
                    cnt_q <= PHASE;
                    state_q <= ST_DONE;
                    if (!is_write_cmd(cmd_q)) begin
                        // Only selected lanes carry data
                        rsp_rdata <= {
                            upper_lane_select ? 9'h000 : data_s[17:9],
                            lower_lane_select ? 9'h000 : data_s[8:0]};
                    end
                end
            end
            ST_DONE: begin
                chip_enable_active_low <= 1'b1;
                chip_enable_active_high <= 1'b0;
                flag_access_select <= 1'b1;
                data_lines_oe <= 1'b0;
                upper_lane_select <= 1'b1;
                lower_lane_select <= 1'b1;
                if (tok_busy_q && cmd_q == `DPSC_CMD_SEM_RD) begin
                    tok_busy_q <= 1'b0;
                    tok_done <= 1'b1;
                    tok_granted <= ~rsp_rdata[0];
                end else if (!tok_busy_q) begin
                    rsp_valid <= 1'b1;
                end
                cnt_q <= PHASE;
                state_q <= ST_RECOV;
            end
            ST_RECOV: begin
                if (phase_end) begin
                    state_q <= ST_IDLE;
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Static pins, busy direction, status and test port
    // -------------------------------------------------------------------------
    reg [7:0] tck_cnt_q;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sleep_input <= 1'b0;
            master_select <= 1'b0;
            busy_n_o <= 1'b1;
            busy_n_oe <= 1'b0;
            busy_seen_n <= 1'b1;
            int_seen_n <= 1'b1;
            tap_clk <= 1'b0;
            tap_rst_n <= 1'b0;
            tck_cnt_q <= 8'h00;
        end else begin
            // Sleep changes only between accesses
            if (state_q == ST_IDLE) begin
                sleep_input <= sleep_req;
            end
            master_select <= master_req;
            // Drive busy only toward a slave device
            busy_n_oe <= ~master_req;
            busy_n_o <= 1'b1;
            busy_seen_n <= stat_s[1];
            int_seen_n <= stat_s[0];
            tap_rst_n <= ~tap_rst_req;
            // Test clock halted during sleep, half period per divider count
            if (sleep_input) begin
                tap_clk <= 1'b0;
                tck_cnt_q <= 8'h00;
            end else if (tck_cnt_q + 8'h01 >= `DPSC_TCK_DIV) begin
                tap_clk <= ~tap_clk;
                tck_cnt_q <= 8'h00;
            end else begin
                tck_cnt_q <= tck_cnt_q + 8'h01;
            end
        end
    end
endmodule

//--- tb/dpsc_port_host_monitor.sv
`timescale 1ns/1ps
// ----
// Pin discipline of one host port
// ----
module dpsc_port_host_monitor (
    input wire clk_sys,
    input wire rst,
    input wire req_ready,
    input wire rsp_valid,
    input wire tok_done,
    input wire tap_rst_req,
    input wire chip_enable_active_low,
    input wire chip_enable_active_high,
    input wire rw_n,
    input wire oe_n,
    input wire flag_access_select,
    input wire lower_lane_select,
    input wire sleep_input,
    input wire data_lines_oe,
    input wire master_select,
    input wire busy_n_o,
    input wire busy_n_oe,
    input wire tap_clk,
    input wire tap_rst_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire sel = !chip_enable_active_low && chip_enable_active_high;

    chk_flag_chip_apart: assert property (sel |-> flag_access_select)
        else $error("flag select while chip enabled");
    chk_write_drives: assert property (sel && !rw_n |-> data_lines_oe)
        else $error("write without data drive");
    chk_read_no_fight: assert property (!oe_n |-> !data_lines_oe)
        else $error("host drives during read");
    chk_sleep_idle: assert property (
        sleep_input |-> !sel && flag_access_select && rw_n)
        else $error("access while asleep");
    chk_flag_write_edge: assert property (
        $rose(rw_n) && !flag_access_select |-> !sel && !lower_lane_select)
        else $error("bad flag write edge");
    chk_busy_dir: assert property (
        !$past(rst) |-> (busy_n_oe == !master_select) && busy_n_o)
        else $error("busy pin direction wrong");
    chk_tap_reset: assert property (!$past(rst) |-> tap_rst_n == !$past(tap_rst_req))
        else $error("test reset not following");
    chk_tap_rate: assert property (
        !$past(rst) && !$past(sleep_input) |-> tap_clk != $past(tap_clk))
        else $error("test clock not at half rate");
    chk_tap_sleep: assert property (sleep_input ##1 sleep_input |-> !tap_clk)
        else $error("test clock runs in sleep");
    chk_req_answer: assert property (req_ready |-> ##[1:40] (rsp_valid || tok_done))
        else $error("request never answered");
endmodule

bind dpsc_port_host dpsc_port_host_monitor u_mon (.*);

//--- tb/dpsc_dev_model.sv
`timescale 1ns/1ps
// ----
// One port of the dual-port device
// ----
module dpsc_dev_model (
    input wire clk_sys,
    input wire chip_enable_active_low,
    input wire chip_enable_active_high,
    input wire rw_n,
    input wire oe_n,
    input wire flag_access_select,
    input wire upper_lane_select,
    input wire lower_lane_select,
    input wire sleep_input,
    input wire [18:0] word_address,
    input wire [17:0] data_lines_o,
    input wire data_lines_oe,
    input wire master_select,
    input wire busy_drv,
    input wire [7:0] other_hold,
    output wire [17:0] data_lines_i,
    output wire busy_n_dev,
    output wire busy_oe_dev
);
    reg [17:0] mem [0:524287];
    reg [7:0] flag_q = 8'hFF;
    reg tog_q = 1'h0;
    wire [2:0] fi = word_address[2:0];
    wire en = !sleep_input && !chip_enable_active_low && chip_enable_active_high;
    wire fen = !sleep_input && !en && !flag_access_select;
    wire rd = rw_n && !oe_n && (en && flag_access_select || fen);
    wire [17:0] lane = {{9{!upper_lane_select}}, {9{!lower_lane_select}}};
    wire [17:0] dev = en ? mem[word_address] : {18{flag_q[fi] | other_hold[fi]}};
    wire [17:0] drv = (rd ? lane : 18'h0) | {18{data_lines_oe}};
    // Floating lanes wander each cycle
    assign data_lines_i = drv & (rd ? dev : data_lines_o) | ~drv & {9{tog_q, !tog_q}};
    assign busy_oe_dev = master_select;
    assign busy_n_dev = busy_drv;
    always @(posedge clk_sys) begin
        tog_q <= !tog_q;
    end
    always @(posedge rw_n) begin
        if (en && flag_access_select) begin
            if (!upper_lane_select) begin
                mem[word_address][17:9] <= data_lines_i[17:9];
            end
            if (!lower_lane_select) begin
                mem[word_address][8:0] <= data_lines_i[8:0];
            end
        end else if (fen && !lower_lane_select) begin
            flag_q[fi] <= data_lines_i[0] | other_hold[fi];
        end
    end
endmodule

//--- tb/dpsc_port_host_tb.sv
`timescale 1ns/1ps
// ----
// Host port bench
// ----
module dpsc_port_host_tb;
    typedef struct packed {
        logic [1:0] c;
        logic [18:0] a;
        logic [17:0] w;
        logic [1:0] l;
        logic [17:0] e;
    } dpsc_row_t;
    logic clk_sys = 1'h0, rst = 1'h1, req_valid = 1'h0, tok_req = 1'h0, sleep_req = 1'h0;
    logic master_req = 1'h0, tap_rst_req = 1'h0, int_n_i = 1'h1, busy_drv = 1'h1;
    logic [1:0] req_cmd = 2'h0, req_lane_n = 2'h0;
    logic [18:0] req_addr = 19'h0;
    logic [17:0] req_wdata = 18'h0, r;
    logic [2:0] tok_flag = 3'h0;
    logic [7:0] other_hold = 8'h08;
    wire req_ready, rsp_valid, tok_done, tok_granted, chip_enable_active_low, rw_n, oe_n;
    wire chip_enable_active_high, flag_access_select, upper_lane_select, lower_lane_select;
    wire sleep_input, data_lines_oe, master_select, busy_n_o, busy_n_oe, busy_seen_n;
    wire int_seen_n, tap_clk, tap_rst_n, busy_n_dev, busy_oe_dev, busy_n_i;
    wire [17:0] rsp_rdata, data_lines_o, data_lines_i;
    wire [18:0] word_address;
    integer fails = 0, compares = 0, i;
    dpsc_row_t rows [0:11] = '{
        '{2'h1, 19'h00005, 18'h2A5A5, 2'h0, 18'h0},
        '{2'h1, 19'h40005, 18'h11111, 2'h0, 18'h0},
        '{2'h0, 19'h00005, 18'h0, 2'h0, 18'h2A5A5},
        '{2'h1, 19'h00005, 18'h3FFFF, 2'h2, 18'h0},
        '{2'h0, 19'h00005, 18'h0, 2'h0, 18'h2A5FF},
        '{2'h0, 19'h00005, 18'h0, 2'h1, 18'h2A400},
        '{2'h0, 19'h40005, 18'h0, 2'h1, 18'h11000},
        '{2'h3, 19'h00006, 18'h0, 2'h0, 18'h0},
        '{2'h2, 19'h00006, 18'h0, 2'h0, 18'h0},
        '{2'h3, 19'h00006, 18'h1, 2'h0, 18'h0},
        '{2'h2, 19'h7FFFE, 18'h0, 2'h2, 18'h001FF},
        '{2'h2, 19'h00001, 18'h0, 2'h0, 18'h3FFFF}
    };

    always #50 clk_sys = ~clk_sys;
    assign busy_n_i = busy_n_oe ? busy_n_o : (busy_oe_dev ? busy_n_dev : 1'h1);
    dpsc_port_host uut (.*);
    dpsc_dev_model dev (.*);

    task chk(input [17:0] g, input [17:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task final_report;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task finish_acc;
        integer n;
        n = 0;
        while (req_ready !== 1'h1 && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        req_valid = 1'h0;
        while (rsp_valid !== 1'h1 && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        chk({17'h0, rsp_valid}, 18'h1);
        r = rsp_rdata;
    endtask

    task acc(input [1:0] c, input [18:0] a, input [17:0] w, input [1:0] l);
        @(negedge clk_sys);
        req_cmd = c;
        req_addr = a;
        req_wdata = w;
        req_lane_n = l;
        req_valid = 1'h1;
        finish_acc;
    endtask

    task tok(input [2:0] f, input g);
        integer n;
        @(negedge clk_sys);
        tok_flag = f;
        tok_req = 1'h1;
        n = 0;
        while (tok_done !== 1'h1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        tok_req = 1'h0;
        chk({17'h0, tok_done}, 18'h1);
        chk({17'h0, tok_granted}, {17'h0, g});
    endtask

    initial begin
        repeat (8) @(negedge clk_sys);
        chk({15'h0, chip_enable_active_low, chip_enable_active_high, tap_rst_n}, 18'h4);
        rst = 1'h0;
        for (i = 0; i < 12; i++) begin
            acc(rows[i].c, rows[i].a, rows[i].w, rows[i].l);
            if (!rows[i].c[0]) chk(r, rows[i].e);
        end
        tok(3'h3, 1'h0);
        tok(3'h2, 1'h1);
        @(negedge clk_sys);
        sleep_req = 1'h1;
        int_n_i = 1'h0;
        master_req = 1'h1;
        busy_drv = 1'h0;
        repeat (6) @(negedge clk_sys);
        chk({15'h0, sleep_input, int_seen_n, busy_seen_n}, 18'h4);
        req_cmd = 2'h0;
        req_addr = 19'h00005;
        req_lane_n = 2'h0;
        req_valid = 1'h1;
        repeat (10) begin
            @(negedge clk_sys);
            chk({17'h0, req_ready}, 18'h0);
        end
        sleep_req = 1'h0;
        master_req = 1'h0;
        int_n_i = 1'h1;
        tap_rst_req = 1'h1;
        finish_acc;
        chk(r, 18'h2A5FF);
        chk({15'h0, tap_rst_n, int_seen_n, busy_seen_n}, 18'h3);
        final_report;
    end

    // About six times the expected run
    initial begin
        #100000;
        fails++;
        final_report;
    end
endmodule
